/* eeprom_pkg.sv */
// Shared constants and types for the two-wire memory slave.
package eeprom_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LINK_PERIOD_NS = 64;
  localparam int unsigned POWER_UP_READY_DELAY_MS = 1;
  localparam int unsigned POWER_UP_READY_DELAY_NS = POWER_UP_READY_DELAY_MS * 1000000;
  localparam int unsigned INTERNAL_WRITE_DURATION_MS = 5;
  localparam int unsigned INTERNAL_WRITE_DURATION_NS = INTERNAL_WRITE_DURATION_MS * 1000000;
  // Longest times round down to whole cycles.
  localparam int unsigned POWER_UP_READY_CYCLES = POWER_UP_READY_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_DURATION_NS / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_STD_NS = 100;
  localparam int unsigned GLITCH_FAST_PLUS_NS = 50;
  // Least times round up to whole link cycles.
  localparam logic [1:0] FILT_STD_CYC =
    2'((GLITCH_STD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [1:0] FILT_FAST_PLUS_CYC =
    2'((GLITCH_FAST_PLUS_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned MEM_DEPTH = 16384;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned PAGE_DEPTH = 64;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [5:0] PAGE_LAST = 6'h3f;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_ACK = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101
  } link_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_type;

  typedef struct packed {
    logic fast_plus;
    logic wp;
    logic [2:0] strap;
  } pin_set_type;
endpackage

/* eeprom_link_slave.sv */
// Two-wire serial memory slave: bus engine on the link clock, power-up and write timers on clk.
`timescale 1ns/1ps
module eeprom_link_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = POWER_UP_READY_CYCLES,
  parameter int unsigned WRITE_CYCLES = INTERNAL_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic power_good,
  input wire logic fast_plus_mode,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  input wire logic write_protect,
  output logic device_ready,
  output logic write_busy
);

  // A floating pin resolves to low, as the pad pull-down would make it.
  function automatic logic pulled_low(input logic p);
    if (p == 1'b1) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // ---------------- clk domain: power-on state and write cycle timer ----------------
  logic pg_s1_r, pg_s2_r, ready_r, busy_r, tog_s1_r, tog_s2_r, tog_s3_r, wr_tog_r;
  logic [31:0] por_cnt_r, wr_cnt_r;
  wire write_start = tog_s2_r ^ tog_s3_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      pg_s1_r <= power_good;
      pg_s2_r <= pg_s1_r;
      tog_s1_r <= wr_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_r <= 1'b0;
      por_cnt_r <= 32'h0;
    end else if (!pg_s2_r) begin
      ready_r <= 1'b0;
      por_cnt_r <= 32'h0;
    end else if (!ready_r) begin
      if (por_cnt_r == POWER_UP_CYCLES - 1) begin
        ready_r <= 1'b1;
      end
      por_cnt_r <= por_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      wr_cnt_r <= 32'h0;
    end else if (write_start) begin
      busy_r <= 1'b1;
      wr_cnt_r <= 32'h0;
    end else if (busy_r) begin
      busy_r <= (wr_cnt_r != WRITE_CYCLES - 1);
      wr_cnt_r <= wr_cnt_r + 32'h1;
    end
  end

  assign device_ready = ready_r;
  assign write_busy = busy_r;

  // ---------------- link domain: input synchronisers and glitch filters ----------------
  logic ready_l1_r, ready_l2_r, busy_l1_r, busy_l2_r;
  pin_set_type pins_s1_r, pins_s2_r;
  logic [1:0] raw_s1_r, raw_s2_r, flt_v;
  bus_lines_type bus_f, bus_prev_r;
  wire pin_set_type pins_raw = '{fast_plus: fast_plus_mode,
                                 wp: pulled_low(write_protect),
                                 strap: {pulled_low(strap_addr_bit2),
                                         pulled_low(strap_addr_bit1),
                                         pulled_low(strap_addr_bit0)}};
  wire [1:0] filt_lim = pins_s2_r.fast_plus ? FILT_FAST_PLUS_CYC : FILT_STD_CYC;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_l1_r <= 1'b0;
      ready_l2_r <= 1'b0;
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
      pins_s1_r <= '0;
      pins_s2_r <= '0;
      raw_s1_r <= 2'h3;
      raw_s2_r <= 2'h3;
      bus_prev_r <= '1;
    end else begin
      ready_l1_r <= ready_r;
      ready_l2_r <= ready_l1_r;
      busy_l1_r <= busy_r;
      busy_l2_r <= busy_l1_r;
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      raw_s1_r <= {scl_in, sda_in};
      raw_s2_r <= raw_s1_r;
      bus_prev_r <= bus_f;
    end
  end

  // A line takes a new level only after it has held it for more than the glitch width.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filter
      logic [1:0] fcnt_r;
      logic flt_r;
      always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
          fcnt_r <= 2'h0;
          flt_r <= 1'b1;
        end else if (raw_s2_r[g] == flt_r) begin
          fcnt_r <= 2'h0;
        end else if (fcnt_r == filt_lim) begin
          flt_r <= raw_s2_r[g];
          fcnt_r <= 2'h0;
        end else begin
          fcnt_r <= fcnt_r + 2'h1;
        end
      end
      assign flt_v[g] = flt_r;
    end
  endgenerate
  assign bus_f = flt_v;

  // Edges and conditions come only from filtered lines; SCL is never driven here.
  wire scl_rise = bus_f.scl & ~bus_prev_r.scl;
  wire scl_fall = ~bus_f.scl & bus_prev_r.scl;
  wire start_ev = bus_f.scl & bus_prev_r.scl & bus_prev_r.sda & ~bus_f.sda;
  wire stop_ev = bus_f.scl & bus_prev_r.scl & ~bus_prev_r.sda & bus_f.sda;

  // ---------------- link domain: protocol engine ----------------
  link_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic rd_r, rd_nxt, wp_rej_r, wp_rej_nxt, have_r, have_nxt, mack_r, mack_nxt;
  logic low_r, low_nxt;
  logic wr_pend_r, commit_r;
  logic [PAGE_W-1:0] commit_idx_r;
  logic [ADDR_W-PAGE_W-1:0] commit_base_r;
  logic [PAGE_DEPTH-1:0] page_vld_r;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] page_buf [PAGE_DEPTH];

  wire link_ok = ready_l2_r;
  wire busy_any = wr_pend_r | busy_l2_r | commit_r;
  wire [7:0] rd_byte = mem[addr_r];
  wire addr_match = shift_r[7:1] == {DEV_TYPE_CODE, pins_s2_r.strap};
  wire byte_done = scl_fall & (cnt_r == BITS_PER_BYTE);
  wire data_byte = (st_r == ST_RX) & (idx_r == IDX_DATA);
  wire buf_wr = data_byte & byte_done & ~wp_rej_r;
  wire commit_go = link_ok & stop_ev & have_r & ~wp_rej_r;
  wire [ADDR_W-1:0] page_inc = {addr_r[ADDR_W-1:PAGE_W], addr_r[PAGE_W-1:0] + 6'h1};

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    idx_nxt = idx_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    wp_rej_nxt = wp_rej_r;
    have_nxt = have_r;
    mack_nxt = mack_r;
    low_nxt = low_r;
    if (!link_ok) begin
      st_nxt = ST_IDLE;
      low_nxt = 1'b0;
      have_nxt = 1'b0;
    end else if (start_ev) begin
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      idx_nxt = IDX_ADDR_HI;
      low_nxt = 1'b0;
      have_nxt = 1'b0;
      wp_rej_nxt = 1'b0;
    end else if (stop_ev) begin
      st_nxt = ST_IDLE;
      low_nxt = 1'b0;
      have_nxt = 1'b0;
    end else begin
      if (scl_rise && st_r != ST_IDLE) begin
        cnt_nxt = cnt_r + 4'h1;
        if (st_r == ST_ADDR || st_r == ST_RX) begin
          shift_nxt = {shift_r[6:0], bus_f.sda};
        end
        if (st_r == ST_MACK) begin
          mack_nxt = ~bus_f.sda;
        end
      end
      case (st_r)
        ST_ADDR: begin
          if (byte_done) begin
            cnt_nxt = 4'h0;
            if (addr_match && !busy_any) begin
              st_nxt = ST_ACK;
              low_nxt = 1'b1;
              rd_nxt = shift_r[0];
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (byte_done) begin
            cnt_nxt = 4'h0;
            if (data_byte && wp_rej_r) begin
              st_nxt = ST_IDLE;
            end else begin
              st_nxt = ST_ACK;
              low_nxt = 1'b1;
              if (idx_r == IDX_ADDR_HI) begin
                addr_nxt[ADDR_W-1:8] = shift_r[ADDR_W-9:0];
                idx_nxt = IDX_ADDR_LO;
              end else if (idx_r == IDX_ADDR_LO) begin
                addr_nxt[7:0] = shift_r;
                idx_nxt = IDX_DATA;
              end else begin
                addr_nxt = page_inc;
                have_nxt = 1'b1;
              end
            end
          end
        end
        ST_ACK, ST_MACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            low_nxt = 1'b0;
            if (st_r == ST_MACK && !mack_r) begin
              st_nxt = ST_IDLE;
            end else if (rd_r) begin
              st_nxt = ST_TX;
              shift_nxt = rd_byte;
              low_nxt = ~rd_byte[7];
              addr_nxt = addr_r + 14'h1;
            end else begin
              st_nxt = ST_RX;
              if (idx_r == IDX_DATA && !have_r) begin
                wp_rej_nxt = pins_s2_r.wp;
              end
            end
          end
        end
        ST_TX: begin
          if (byte_done) begin
            st_nxt = ST_MACK;
            cnt_nxt = 4'h0;
            low_nxt = 1'b0;
          end else if (scl_fall) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            low_nxt = ~shift_r[6];
          end
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h0;
      idx_r <= IDX_ADDR_HI;
      addr_r <= '0;
      rd_r <= 1'b0;
      wp_rej_r <= 1'b0;
      have_r <= 1'b0;
      mack_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      wp_rej_r <= wp_rej_nxt;
      have_r <= have_nxt;
      mack_r <= mack_nxt;
      low_r <= low_nxt;
    end
  end

  // The output latch only ever releases or pulls low; the data level stays at zero.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~low_nxt;
    end
  end

  // The write cycle is requested by a toggle; the pending flag covers the crossing delay.
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tog_r <= 1'b0;
      wr_pend_r <= 1'b0;
      commit_r <= 1'b0;
      commit_idx_r <= '0;
      commit_base_r <= '0;
      page_vld_r <= '0;
    end else begin
      if (commit_go) begin
        wr_tog_r <= ~wr_tog_r;
        wr_pend_r <= 1'b1;
        commit_r <= 1'b1;
        commit_idx_r <= '0;
        commit_base_r <= addr_r[ADDR_W-1:PAGE_W];
      end else begin
        if (busy_l2_r) begin
          wr_pend_r <= 1'b0;
        end
        if (commit_r) begin
          commit_idx_r <= commit_idx_r + 6'h1;
          commit_r <= (commit_idx_r != PAGE_LAST);
        end
      end
      if (commit_r && commit_idx_r == PAGE_LAST) begin
        page_vld_r <= '0;
      end else if (start_ev && !commit_r) begin
        page_vld_r <= '0;
      end else if (buf_wr && link_ok) begin
        page_vld_r[addr_r[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // Storage arrays carry no reset; their contents are undefined until written.
  always_ff @(posedge link_clk) begin
    if (buf_wr && link_ok) begin
      page_buf[addr_r[PAGE_W-1:0]] <= shift_r;
    end
    if (commit_r && page_vld_r[commit_idx_r]) begin
      mem[{commit_base_r, commit_idx_r}] <= page_buf[commit_idx_r];
    end
  end

  // ---------------- checks ----------------
  a_sda_never_high: assert property (@(posedge link_clk) disable iff (!reset_n)
    sda_out == 1'b0) else $error("data line driven high");
  a_drive_after_fall: assert property (@(posedge link_clk) disable iff (!reset_n)
    ($fell(sda_oe_n) && $past(st_r) != ST_IDLE) |-> $past(scl_fall))
    else $error("data pulled low without a falling clock");
  a_ack_on_match: assert property (@(posedge link_clk) disable iff (!reset_n)
    (st_r == ST_ADDR && byte_done && addr_match && !busy_any && link_ok && !start_ev && !stop_ev)
    |=> (!sda_oe_n && st_r == ST_ACK)) else $error("matching address not acknowledged");
  a_addr_mismatch: assert property (@(posedge link_clk) disable iff (!reset_n)
    (st_r == ST_ADDR && byte_done && !addr_match) |=> sda_oe_n && st_r == ST_IDLE)
    else $error("foreign address acknowledged");
  a_busy_no_ack: assert property (@(posedge link_clk) disable iff (!reset_n)
    (st_r == ST_ADDR && byte_done && busy_any) |=> sda_oe_n[*2])
    else $error("address acknowledged during write cycle");
  a_wp_refuse: assert property (@(posedge link_clk) disable iff (!reset_n)
    (data_byte && byte_done && wp_rej_r) |=> (sda_oe_n && st_r == ST_IDLE && !have_r))
    else $error("protected data byte acknowledged");
  a_power_abandon: assert property (@(posedge link_clk) disable iff (!reset_n)
    !ready_l2_r |=> ##1 (sda_oe_n && st_r == ST_IDLE)) else $error("transfer kept without power");
  a_filter_hold: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(bus_f.scl) |-> ($past(raw_s2_r[1], 1) == bus_f.scl && $past(raw_s2_r[1], 2) == bus_f.scl))
    else $error("clock line change passed the filter early");
  a_ready_delay: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ready_r) |-> (por_cnt_r == POWER_UP_CYCLES && $past(pg_s2_r, 2)))
    else $error("ready raised at the wrong time");
  a_power_loss: assert property (@(posedge clk) disable iff (!reset_n)
    !pg_s2_r |=> !ready_r) else $error("ready held without power good");

  c_read_ack: cover property (@(posedge link_clk) disable iff (!reset_n)
    st_r == ST_ACK && rd_r ##[1:200] st_r == ST_TX);
  c_write_commit: cover property (@(posedge link_clk) disable iff (!reset_n) commit_go);
  c_wp_reject: cover property (@(posedge link_clk) disable iff (!reset_n)
    data_byte && byte_done && wp_rej_r);
  c_busy_poll: cover property (@(posedge link_clk) disable iff (!reset_n)
    st_r == ST_ADDR && byte_done && addr_match && busy_any);
endmodule

/* bus_master.sv */
// Behavioural two-wire bus master that makes the bus clock and frames every transfer.
`timescale 1ns/1ps
module bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Half period of the bus clock in system cycles; the bench may slow the bus down.
  int half = 5;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_drv <= 1'b0;
    tick(half);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sda_drv <= 1'b1;
    tick(half);
  endtask
  // Data moves one cycle after the clock falls, so the slave never sees it beside the edge.
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    tick(half);
    scl <= 1'b1;
    tick(half);
    r = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~mack, r);
  endtask
  // A short spurious high pulse on the clock line while it should be low.
  task automatic scl_glitch(input int ns);
    #20;
    scl = 1'b1;
    #(ns);
    scl = 1'b0;
    tick(1);
  endtask
endmodule

/* i2c_eeprom_slave_interface_test.sv */
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/1ps
module i2c_eeprom_slave_interface_test;
  import eeprom_pkg::*;
  localparam int unsigned PU = 50;
  localparam int unsigned WR = 200;
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_good = 1'b0;
  logic fast_plus_mode = 1'b1;
  logic strap_addr_bit0 = 1'b1;
  logic strap_addr_bit1 = 1'b0;
  logic strap_addr_bit2 = 1'b1;
  logic write_protect = 1'b0;
  logic scl, sda_drv, sda_out, sda_oe_n, device_ready, write_busy, oe_q, ack;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // Open-drain data line with a pull-up: any party pulling low wins.
  wire sda = sda_drv & (sda_oe_n | sda_out);

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end

  eeprom_link_slave #(.POWER_UP_CYCLES(PU), .WRITE_CYCLES(WR)) eeprom_link_slave_i (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .power_good(power_good),
    .fast_plus_mode(fast_plus_mode), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .strap_addr_bit0(strap_addr_bit0),
    .strap_addr_bit1(strap_addr_bit1), .strap_addr_bit2(strap_addr_bit2),
    .write_protect(write_protect), .device_ready(device_ready), .write_busy(write_busy));
  bus_master bus_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] addr_of(input logic [2:0] s, input logic rdb);
    return {4'ha, s, rdb};
  endfunction
  task automatic wait_ready();
    for (int i = 0; i < PU + 10 && device_ready !== 1'b1; i++)
      clocks(1);
  endtask
  // Opens a write to strap 5 and loads the address counter; ok is the anded acknowledges.
  task automatic point(input logic [13:0] a, output logic ok);
    logic k1, k2, k3;
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b0), k1);
    bus_master_i.send({2'h0, a[13:8]}, k2);
    bus_master_i.send(a[7:0], k3);
    ok = k1 & k2 & k3;
  endtask
  task automatic read_at(input logic [13:0] a, output logic [7:0] d);
    logic ok;
    point(a, ok);
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b1), ack);
    bus_master_i.recv(1'b0, d);
    bus_master_i.stop();
  endtask

  // The data line is never driven high, and the slave's drive never moves while the bus clock is high with power good.
  always @(posedge link_clk) begin
    oe_q <= sda_oe_n;
    if (sda_oe_n === 1'b0)
      check({7'h0, sda_out}, 8'h00);
    if (scl === 1'b1 && power_good === 1'b1 && oe_q !== sda_oe_n)
      check(8'h01, 8'h00);
  end

  task automatic test_power_up();
    clocks(PU + 50);
    check({7'h0, device_ready}, 8'h00);
    power_good <= 1'b1;
    wait_ready();
    check({7'h0, device_ready}, 8'h01);
  endtask

  task automatic test_address();
    for (int s = 0; s < 8; s++) begin
      bus_master_i.start();
      bus_master_i.send(addr_of(3'(s), 1'b0), ack);
      bus_master_i.stop();
      check({7'h0, ack}, {7'h0, s == 5});
    end
    bus_master_i.start();
    bus_master_i.send(8'hba, ack);
    bus_master_i.stop();
    check({7'h0, ack}, 8'h00);
    strap_addr_bit0 <= 1'bz;
    strap_addr_bit1 <= 1'bz;
    strap_addr_bit2 <= 1'bz;
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h0, 1'b0), ack);
    bus_master_i.stop();
    check({7'h0, ack}, 8'h01);
    strap_addr_bit0 <= 1'b1;
    strap_addr_bit1 <= 1'b0;
    strap_addr_bit2 <= 1'b1;
  endtask

  task automatic test_write_read();
    logic ok;
    logic [7:0] d0, d1;
    write_protect <= 1'bz;
    point(14'h1234, ok);
    check({7'h0, ok}, 8'h01);
    bus_master_i.send(8'h5a, ack);
    check({7'h0, ack}, 8'h01);
    bus_master_i.send(8'hc3, ack);
    bus_master_i.stop();
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b1), ack);
    bus_master_i.stop();
    check({7'h0, ack}, 8'h00);
    for (int i = 0; i < 100 && write_busy !== 1'b1; i++)
      clocks(1);
    for (int i = 0; i < WR + 20 && write_busy !== 1'b0; i++)
      clocks(1);
    point(14'h1234, ok);
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b1), ack);
    bus_master_i.recv(1'b1, d0);
    bus_master_i.recv(1'b0, d1);
    bus_master_i.stop();
    check(d0, 8'h5a);
    check(d1, 8'hc3);
  endtask

  task automatic test_protect();
    logic ok;
    logic [7:0] d;
    write_protect <= 1'b1;
    point(14'h1234, ok);
    bus_master_i.send(8'h00, ack);
    bus_master_i.stop();
    check({7'h0, ack}, 8'h00);
    write_protect <= 1'b0;
    clocks(60);
    check({7'h0, write_busy}, 8'h00);
    read_at(14'h1234, d);
    check(d, 8'h5a);
  endtask

  // Power is lost while the slave is pulling the line low for a read bit.
  task automatic test_power_loss();
    logic ok;
    point(14'h1234, ok);
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b1), ack);
    clocks(4);
    check({7'h0, sda_oe_n}, 8'h00);
    power_good <= 1'b0;
    clocks(8);
    check({7'h0, device_ready}, 8'h00);
    check({7'h0, sda_oe_n}, 8'h01);
    bus_master_i.stop();
    power_good <= 1'b1;
    wait_ready();
    check({7'h0, device_ready}, 8'h01);
    bus_master_i.start();
    bus_master_i.send(addr_of(3'h5, 1'b0), ack);
    bus_master_i.stop();
    check({7'h0, ack}, 8'h01);
  endtask

  // The standard class runs on a slower bus with a longer glitch than fast-plus.
  task automatic test_glitch();
    for (int m = 0; m < 2; m++) begin
      fast_plus_mode <= m[0];
      bus_master_i.half = (m == 0) ? 20 : 5;
      clocks(4);
      bus_master_i.start();
      bus_master_i.scl_glitch((m == 0) ? 80 : 40);
      bus_master_i.send(addr_of(3'h5, 1'b0), ack);
      bus_master_i.stop();
      check({7'h0, ack}, 8'h01);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    test_power_up();
    test_address();
    test_write_read();
    test_protect();
    test_power_loss();
    test_glitch();
    summarize();
  end
endmodule
